/* File: hdl/dma_event_queue_bank.sv */
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module dma_event_queue_bank (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic evt_valid,
  input wire logic evt_quick,
  input wire logic [5:0] evt_channel,
  input wire evq_pkg::trig_type evt_trig,
  output logic evt_accept,
  input wire logic [3:0] request_ready,
  input wire logic [3:0] ctrl_idle,
  output logic [3:0] request_valid,
  output evq_pkg::entry_type [3:0] request_entry,
  output logic [3:0][2:0] queue_priority,
  output logic err_irq
);

  typedef struct packed {
    logic [evq_pkg::DMA_CHANNELS-1:0][1:0] dma_map;
    logic [evq_pkg::QUICK_CHANNELS-1:0][1:0] quick_map;
    logic [3:0][2:0] prio;
    logic [3:0][3:0] thresh;
    logic [3:0] err;
    logic [3:0] mask;
    logic irq;
    evq_pkg::bus_state_type bus;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic evt_accept;
    logic [3:0] req_valid;
    evq_pkg::entry_type [3:0] req_entry;
  } bank_state_type;

  bank_state_type st;
  bank_state_type next_st;
  logic [1:0] rst_sync;
  logic rst_n;

  queue_port_if qp [evq_pkg::QUEUES] ();

  logic [3:0] push_q;
  logic [3:0] pop_q;
  logic [3:0] clr_q;
  logic [3:0][4:0] q_count;
  logic [3:0][3:0] q_head;
  logic [3:0][4:0] q_mark;
  logic [3:0] q_over;
  logic [3:0] q_exceeding;
  evq_pkg::entry_type [3:0] q_head_data;
  evq_pkg::entry_type [3:0] q_rd_data;
  evq_pkg::entry_type new_entry;

  // Register selects, shared by the read and the write path so both agree
  typedef struct packed {
    logic dma_map;
    logic quick_map;
    logic prio;
    logic thresh;
    logic err;
    logic mask;
    logic status;
    logic entry;
  } reg_sel_type;

  function automatic reg_sel_type decode_reg(input logic [11:0] addr);
    reg_sel_type sel;
    sel = '0;
    sel.dma_map = addr < evq_pkg::QUICK_CHANNEL_QUEUE_MAP_OFS;
    sel.quick_map = addr == evq_pkg::QUICK_CHANNEL_QUEUE_MAP_OFS;
    sel.prio = addr == evq_pkg::QUEUE_PRIORITY_REG_OFS;
    sel.thresh = addr == evq_pkg::WATERMARK_THRESHOLD_OFS;
    sel.err = addr == evq_pkg::CONTROLLER_ERROR_REG_OFS;
    sel.mask = addr == evq_pkg::ERROR_MASK_OFS;
    sel.status = addr >= evq_pkg::QUEUE_STATUS_OFS
                 && addr < evq_pkg::QUEUE_STATUS_OFS + 12'h010;
    sel.entry = addr >= evq_pkg::QUEUE_ENTRY_OFS && addr < evq_pkg::QUEUE_ENTRY_END;
    return sel;
  endfunction

  // Channel number held by one field of a map register
  function automatic logic [5:0] map_slot(input logic [2:0] reg_index, input int k);
    return 6'(reg_index * evq_pkg::MAP_FIELDS_PER_REG + k);
  endfunction

  // Places a value in the low bits of one nibble-wide field of a word
  function automatic logic [31:0] field_at(input logic [3:0] value, input int slot);
    logic [31:0] word;
    word = '0;
    word[slot*evq_pkg::MAP_FIELD_WIDTH +: evq_pkg::MAP_FIELD_WIDTH] = value;
    return word;
  endfunction

  // Reads one field of a write word
  function automatic logic [3:0] field_of(input logic [31:0] word, input int slot);
    return word[slot*evq_pkg::MAP_FIELD_WIDTH +: evq_pkg::MAP_FIELD_WIDTH];
  endfunction

  function automatic logic [31:0] status_word(input logic [3:0] head, input logic [4:0] count,
                                              input logic [4:0] mark, input logic over);
    logic [31:0] word;
    word = '0;
    word[evq_pkg::STATUS_HEAD_LSB +: 4] = head;
    word[evq_pkg::STATUS_COUNT_LSB +: 5] = count;
    word[evq_pkg::STATUS_MARK_LSB +: 5] = mark;
    word[evq_pkg::STATUS_OVER_BIT] = over;
    return word;
  endfunction

  // Reset release through two flip-flops, assertion stays asynchronous
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  for (genvar g = 0; g < evq_pkg::QUEUES; g++) begin : g_queue
    assign qp[g].push = push_q[g];
    assign qp[g].push_data = new_entry;
    assign qp[g].pop = pop_q[g];
    assign qp[g].clr_flag = clr_q[g];
    assign qp[g].thresh = st.thresh[g];
    assign qp[g].rd_index = paddr[5:2];
    assign q_count[g] = qp[g].count;
    assign q_head[g] = qp[g].head;
    assign q_mark[g] = qp[g].high_mark;
    assign q_over[g] = qp[g].over;
    assign q_exceeding[g] = qp[g].exceeding;
    assign q_head_data[g] = qp[g].head_data;
    assign q_rd_data[g] = qp[g].rd_data;

    event_queue queue_inst (
      .mclk(mclk),
      .rst_n(rst_n),
      .port(qp[g])
    );
  end

  always_comb begin
    logic [1:0] target;
    logic unloaded;
    logic [2:0] map_reg;
    logic [1:0] sel_q;
    logic wr_ack;
    reg_sel_type sel;
    next_st = st;
    push_q = 4'h0;
    pop_q = 4'h0;
    clr_q = 4'h0;
    target = 2'h0;
    unloaded = 1'b0;
    map_reg = paddr[4:2];
    sel_q = paddr[7:6];
    wr_ack = 1'b0;
    sel = decode_reg(paddr);
    new_entry.quick = evt_quick;
    new_entry.trig = evt_trig;
    new_entry.number = evt_channel;

    // A controller taking a request frees its submission slot
    for (int q = 0; q < evq_pkg::QUEUES; q++) begin
      if (st.req_valid[q] && request_ready[q]) begin
        next_st.req_valid[q] = 1'b0;
      end
    end

    // Accept one event per handshake; a refused event simply stays pending upstream
    next_st.evt_accept = 1'b0;
    if (evt_valid && !st.evt_accept) begin
      if (evt_quick) begin
        target = st.quick_map[evt_channel[1:0]];
      end else begin
        target = st.dma_map[evt_channel];
      end
      if (q_count[target] == 5'h00 && ctrl_idle[target] && !st.req_valid[target]) begin
        next_st.req_valid[target] = 1'b1;
        next_st.req_entry[target] = new_entry;
        next_st.evt_accept = 1'b1;
      end else if (q_count[target] != evq_pkg::FULL_COUNT) begin
        push_q[target] = 1'b1;
        next_st.evt_accept = 1'b1;
      end
    end

    // One head per cycle goes to parameter processing; lowest queue number wins
    for (int q = 0; q < evq_pkg::QUEUES; q++) begin
      if (!unloaded && q_count[q] != 5'h00 && request_ready[q] && !st.req_valid[q]) begin
        pop_q[q] = 1'b1;
        next_st.req_valid[q] = 1'b1;
        next_st.req_entry[q] = q_head_data[q];
        unloaded = 1'b1;
      end
    end

    // APB slave: read data is captured in the first access cycle, pready follows
    unique case (st.bus)
      evq_pkg::BUS_IDLE: begin
        next_st.pready = 1'b0;
        if (psel && penable) begin
          next_st.bus = evq_pkg::BUS_RESPOND;
          next_st.pready = 1'b1;
          next_st.pslverr = 1'b0;
          next_st.prdata = 32'h0000_0000;
          if (paddr[1:0] != 2'h0) begin
            next_st.pslverr = 1'b1;
          end else if (sel.dma_map) begin
            for (int k = 0; k < evq_pkg::MAP_FIELDS_PER_REG; k++) begin
              next_st.prdata = next_st.prdata
                | field_at({2'h0, st.dma_map[map_slot(map_reg, k)]}, k);
            end
          end else if (sel.quick_map) begin
            for (int k = 0; k < evq_pkg::QUICK_CHANNELS; k++) begin
              next_st.prdata = next_st.prdata | field_at({2'h0, st.quick_map[k]}, k);
            end
          end else if (sel.prio) begin
            for (int k = 0; k < evq_pkg::QUEUES; k++) begin
              next_st.prdata = next_st.prdata | field_at({1'b0, st.prio[k]}, k);
            end
          end else if (sel.thresh) begin
            for (int k = 0; k < evq_pkg::QUEUES; k++) begin
              next_st.prdata = next_st.prdata | field_at(st.thresh[k], k);
            end
          end else if (sel.err) begin
            next_st.prdata = {28'h0000000, st.err};
          end else if (sel.mask) begin
            next_st.prdata = {28'h0000000, st.mask};
          end else if (sel.status) begin
            next_st.prdata = status_word(q_head[paddr[3:2]], q_count[paddr[3:2]],
                                         q_mark[paddr[3:2]], q_over[paddr[3:2]]);
          end else if (sel.entry) begin
            next_st.prdata = {23'h000000, q_rd_data[sel_q]};
          end else begin
            next_st.pslverr = 1'b1;
          end
        end
      end
      evq_pkg::BUS_RESPOND: begin
        // The master samples pready here, so writes land on this same edge
        next_st.bus = evq_pkg::BUS_IDLE;
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        wr_ack = psel && penable && pwrite && !st.pslverr;
      end
      default: begin
        next_st.bus = evq_pkg::BUS_IDLE;
        next_st.pready = 1'b0;
      end
    endcase

    if (wr_ack) begin
      if (sel.dma_map) begin
        for (int k = 0; k < evq_pkg::MAP_FIELDS_PER_REG; k++) begin
          next_st.dma_map[map_slot(map_reg, k)] = 2'(field_of(pwdata, k));
        end
      end else if (sel.quick_map) begin
        for (int k = 0; k < evq_pkg::QUICK_CHANNELS; k++) begin
          next_st.quick_map[k] = 2'(field_of(pwdata, k));
        end
      end else if (sel.prio) begin
        for (int k = 0; k < evq_pkg::QUEUES; k++) begin
          next_st.prio[k] = 3'(field_of(pwdata, k));
        end
      end else if (sel.thresh) begin
        for (int k = 0; k < evq_pkg::QUEUES; k++) begin
          next_st.thresh[k] = field_of(pwdata, k);
        end
      end else if (sel.err) begin
        next_st.err = st.err & ~pwdata[3:0];
        clr_q = pwdata[3:0];
      end else if (sel.mask) begin
        next_st.mask = pwdata[3:0];
      end
    end

    // A queue still over its threshold re-sets its bit even while being cleared
    for (int q = 0; q < evq_pkg::QUEUES; q++) begin
      if (q_exceeding[q]) begin
        next_st.err[q] = 1'b1;
      end
    end
    next_st.irq = |(next_st.err & next_st.mask);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st.dma_map <= {evq_pkg::DMA_CHANNELS{evq_pkg::MAP_RESET}};
      st.quick_map <= {evq_pkg::QUICK_CHANNELS{evq_pkg::MAP_RESET}};
      st.prio <= {evq_pkg::QUEUES{evq_pkg::PRIORITY_RESET}};
      st.thresh <= {evq_pkg::QUEUES{evq_pkg::THRESHOLD_RESET}};
      st.err <= 4'h0;
      st.mask <= evq_pkg::ERROR_MASK_RESET;
      st.irq <= 1'b0;
      st.bus <= evq_pkg::BUS_IDLE;
      st.pready <= 1'b0;
      st.pslverr <= 1'b0;
      st.prdata <= 32'h0000_0000;
      st.evt_accept <= 1'b0;
      st.req_valid <= 4'h0;
      st.req_entry <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign evt_accept = st.evt_accept;
  assign request_valid = st.req_valid;
  assign request_entry = st.req_entry;
  assign queue_priority = st.prio;
  assign err_irq = st.irq;

endmodule

/* File: hdl/evq_pkg.sv */
package evq_pkg;

  localparam int QUEUES = 4;
  localparam int DEPTH = 16;
  localparam int DMA_CHANNELS = 64;
  localparam int QUICK_CHANNELS = 4;
  localparam logic [4:0] FULL_COUNT = 5'h10;

  // Register byte offsets on the APB side
  localparam logic [11:0] DMA_CHANNEL_QUEUE_MAP_OFS = 12'h000;
  localparam logic [11:0] QUICK_CHANNEL_QUEUE_MAP_OFS = 12'h020;
  localparam logic [11:0] QUEUE_PRIORITY_REG_OFS = 12'h024;
  localparam logic [11:0] WATERMARK_THRESHOLD_OFS = 12'h028;
  localparam logic [11:0] CONTROLLER_ERROR_REG_OFS = 12'h02C;
  localparam logic [11:0] ERROR_MASK_OFS = 12'h030;
  localparam logic [11:0] QUEUE_STATUS_OFS = 12'h040;
  localparam logic [11:0] QUEUE_ENTRY_OFS = 12'h100;
  localparam logic [11:0] QUEUE_ENTRY_END = 12'h200;

  // Field layout
  localparam int MAP_FIELD_WIDTH = 4;
  localparam int MAP_FIELDS_PER_REG = 8;
  localparam int STATUS_HEAD_LSB = 0;
  localparam int STATUS_COUNT_LSB = 8;
  localparam int STATUS_MARK_LSB = 16;
  localparam int STATUS_OVER_BIT = 24;

  // Reset values
  localparam logic [2:0] PRIORITY_RESET = 3'h0;
  localparam logic [3:0] THRESHOLD_RESET = 4'hF;
  localparam logic [3:0] ERROR_MASK_RESET = 4'hF;
  localparam logic [1:0] MAP_RESET = 2'h0;

  typedef enum logic [1:0] {
    TRIG_MANUAL = 2'h0,
    TRIG_EVENT = 2'h1,
    TRIG_CHAINED = 2'h2,
    TRIG_AUTO = 2'h3
  } trig_type;

  typedef struct packed {
    logic quick;
    trig_type trig;
    logic [5:0] number;
  } entry_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h1,
    BUS_RESPOND = 2'h2
  } bus_state_type;

endpackage

/* File: hdl/queue_port_if.sv */
`timescale 1ns/1ps
interface queue_port_if;
  logic push;
  evq_pkg::entry_type push_data;
  logic pop;
  logic clr_flag;
  logic [3:0] thresh;
  logic [3:0] rd_index;
  logic [4:0] count;
  logic [3:0] head;
  logic [4:0] high_mark;
  logic over;
  logic exceeding;
  evq_pkg::entry_type head_data;
  evq_pkg::entry_type rd_data;

  modport bank (
    output push, push_data, pop, clr_flag, thresh, rd_index,
    input count, head, high_mark, over, exceeding, head_data, rd_data
  );
  modport queue (
    input push, push_data, pop, clr_flag, thresh, rd_index,
    output count, head, high_mark, over, exceeding, head_data, rd_data
  );
endinterface

/* File: hdl/event_queue.sv */
`timescale 1ns/1ps
module event_queue (
  input wire logic mclk,
  input wire logic rst_n,
  queue_port_if.queue port
);

  typedef struct packed {
    evq_pkg::entry_type [evq_pkg::DEPTH-1:0] entries;
    logic [3:0] head;
    logic [4:0] count;
    logic [4:0] high_mark;
    logic over;
  } queue_state_type;

  queue_state_type st;
  queue_state_type next_st;

  always_comb begin
    next_st = st;
    // Circular storage: the tail is head plus count, old entries stay as history
    if (port.push) begin
      next_st.entries[4'(st.head + st.count[3:0])] = port.push_data;
    end
    if (port.pop) begin
      next_st.head = 4'(st.head + 4'h1);
    end
    next_st.count = 5'(st.count + {4'h0, port.push} - {4'h0, port.pop});
    if (next_st.count > st.high_mark) begin
      next_st.high_mark = next_st.count;
    end
    if (port.clr_flag) begin
      next_st.over = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (st.count > {1'b0, port.thresh}) begin
      next_st.over = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign port.count = st.count;
  assign port.head = st.head;
  assign port.high_mark = st.high_mark;
  assign port.over = st.over;
  assign port.exceeding = st.count > {1'b0, port.thresh};
  assign port.head_data = st.entries[st.head];
  assign port.rd_data = st.entries[port.rd_index];

endmodule

/* File: dv/dma_event_queue_bank_asserts.sv */
`timescale 1ns/1ps
module dma_event_queue_bank_asserts (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic evt_valid,
  input wire logic evt_accept,
  input wire logic [3:0] request_ready,
  input wire logic [3:0] request_valid,
  input wire evq_pkg::entry_type [3:0] request_entry,
  input wire logic [3:0][2:0] queue_priority,
  input wire logic err_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  property p_reset_clear;
    $rose(arst_n) |-> request_valid == 4'h0 && !err_irq && !pready;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("outputs not clear after reset");
  property p_bus_answer;
    psel && $rose(penable) |-> !pready ##1 pready;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer late");
  property p_accept_cause;
    evt_accept |-> $past(evt_valid) && !$past(evt_accept);
  endproperty
  a_accept_cause: assert property (p_accept_cause)
    else $error("accept without event");
  property p_accept_pulse;
    evt_accept |=> !evt_accept;
  endproperty
  a_accept_pulse: assert property (p_accept_pulse)
    else $error("accept longer than a cycle");
  for (genvar q = 0; q < 4; q++) begin : g_q
    property p_hold_until_taken;
      request_valid[q] && !request_ready[q] |=> request_valid[q] && $stable(request_entry[q]);
    endproperty
    a_hold_until_taken: assert property (p_hold_until_taken)
      else $error("request changed before taken");
    property p_drop_after_take;
      request_valid[q] && request_ready[q] |=> !request_valid[q];
    endproperty
    a_drop_after_take: assert property (p_drop_after_take)
      else $error("request kept after taken");
  end
  property p_entry_write_quiet;
    pready && pwrite && paddr >= evq_pkg::QUEUE_ENTRY_OFS && paddr < evq_pkg::QUEUE_ENTRY_END
      && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  a_entry_write_quiet: assert property (p_entry_write_quiet)
    else $error("entry write flagged");
  property p_prio_by_write;
    !$stable(queue_priority) |-> $past(pready && pwrite);
  endproperty
  a_prio_by_write: assert property (p_prio_by_write)
    else $error("priority changed without write");
  property p_irq_fall;
    $fell(err_irq) |-> $past(pready && pwrite) || $past(pready && pwrite, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt fell without write");
  property p_one_unload;
    !evt_accept |-> $onehot0(request_valid & ~$past(request_valid));
  endproperty
  a_one_unload: assert property (p_one_unload)
    else $error("two queues unloaded in one cycle");
endmodule
bind dma_event_queue_bank dma_event_queue_bank_asserts u_chk (.mclk, .arst_n, .psel, .penable,
  .pwrite, .paddr, .pready, .pslverr, .evt_valid, .evt_accept, .request_ready, .request_valid,
  .request_entry, .queue_priority, .err_irq);

/* File: dv/tc_model.sv */
`timescale 1ns/1ps
module tc_model (
  input wire logic mclk,
  input wire logic [3:0] stall,
  input wire logic [3:0] request_valid,
  input wire evq_pkg::entry_type [3:0] request_entry,
  output logic [3:0] request_ready,
  output logic [3:0] ctrl_idle
);
  evq_pkg::entry_type log [4][$];
  int order [$];
  logic [3:0] busy = 4'h0;
  initial request_ready = 4'h0;
  initial ctrl_idle = 4'h0;
  // A stalled controller is busy with a long transfer: neither ready nor idle
  always @(posedge mclk) begin
    for (int q = 0; q < 4; q++) begin
      if (request_valid[q] && request_ready[q]) begin
        log[q].push_back(request_entry[q]);
        order.push_back(q);
      end
    end
    busy <= request_valid & request_ready;
    request_ready <= ~stall & ~(request_valid & request_ready);
    ctrl_idle <= ~stall & ~busy & ~(request_valid & request_ready);
  end
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, evt_valid = 1'b0, evt_quick = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, w;
  logic pready, pslverr, evt_accept, err_irq, er, ok, qk;
  logic [5:0] evt_channel = 6'h00, ch;
  evq_pkg::trig_type evt_trig = evq_pkg::TRIG_MANUAL;
  logic [3:0] stall = 4'hF, request_ready, ctrl_idle, request_valid;
  evq_pkg::entry_type [3:0] request_entry;
  logic [3:0][2:0] queue_priority;
  int n_fail = 0, compares = 0, seed = 32'h63415A90, cyc = 0, th;
  evq_pkg::entry_type exp [4][$];
  logic [1:0] qmap [4];
  always #2.5 mclk = ~mclk;
  dma_event_queue_bank dut (.mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .evt_valid, .evt_quick, .evt_channel, .evt_trig, .evt_accept,
    .request_ready, .ctrl_idle, .request_valid, .request_entry, .queue_priority, .err_irq);
  tc_model u_tc (.mclk, .stall, .request_valid, .request_entry, .request_ready, .ctrl_idle);
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      $display("mismatch at %0t: timeout", $time);
      end_of_test();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] want, input string s);
    compares++;
    if (got !== want) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h want %h", $time, s, got, want);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] v, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    cmp(rd & m, v, "register read");
  endtask
  function automatic logic [11:0] sa(input int q);
    return evq_pkg::QUEUE_STATUS_OFS + 12'(q * 4);
  endfunction
  function automatic logic [11:0] ea(input int q, input int e);
    return evq_pkg::QUEUE_ENTRY_OFS + 12'(q * 64 + e * 4);
  endfunction
  // A refused event keeps evt_valid up so a later call can resume it
  task automatic send(input logic q, input logic [5:0] c, input evq_pkg::trig_type t, input int lim);
    int n;
    @(posedge mclk);
    evt_valid <= 1'b1;
    evt_quick <= q;
    evt_channel <= c;
    evt_trig <= t;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (evt_accept !== 1'b1 && n < lim);
    ok = (evt_accept === 1'b1);
    if (ok) begin
      evt_valid <= 1'b0;
      exp[q ? qmap[c[1:0]] : c[1:0]].push_back(evq_pkg::entry_type'({q, t, c}));
    end
  endtask
  function automatic int pend();
    pend = 0;
    for (int q = 0; q < 4; q++)
      pend += exp[q].size() - u_tc.log[q].size();
  endfunction
  task automatic drain();
    for (int n = 0; n < 400 && pend() != 0; n++)
      @(posedge mclk);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int q = 0; q < 4; q++)
      rdchk(sa(q), 32'h0, 32'h011F1F0F);
    rdchk(evq_pkg::WATERMARK_THRESHOLD_OFS, 32'hFFFF, 32'hFFFF);
    $display("test reset done");
    for (int r = 0; r < 9; r++) begin
      w = $random(seed) & 32'h33333333;
      apb(1'b1, 12'(r * 4), w);
      if (r == 8) w = w & 32'h3333;
      rdchk(12'(r * 4), w, 32'h33333333);
      if (r < 8)
        apb(1'b1, 12'(r * 4), 32'h32103210);
      else
        for (int c = 0; c < 4; c++) qmap[c] = w[4 * c +: 2];
    end
    w = $random(seed) & 32'h7777;
    apb(1'b1, evq_pkg::QUEUE_PRIORITY_REG_OFS, w);
    repeat (2) @(posedge mclk);
    cmp(queue_priority, {w[14:12], w[10:8], w[6:4], w[2:0]}, "priority");
    $display("test map done");
    th = {$random(seed)} % 15;
    apb(1'b1, evq_pkg::WATERMARK_THRESHOLD_OFS, 32'hFF0F | 32'(th << 4));
    for (int i = 0; i < 17; i++) begin
      send(1'b0, {4'($random(seed)), 2'h1}, evq_pkg::trig_type'(2'(i % 4)), 10);
      cmp(ok, i < 16, "accept");
      repeat (3) @(posedge mclk);
      cmp(err_irq, i >= th, "irq level");
    end
    rdchk(sa(1), 32'h01101000, 32'h011F1F0F);
    rdchk(evq_pkg::CONTROLLER_ERROR_REG_OFS, 32'h2, 32'hF);
    for (int e = 0; e < 16; e++)
      rdchk(ea(1, e), exp[1][e], 32'h1FF);
    apb(1'b1, ea(1, 3), ~{23'h0, exp[1][3]});
    cmp(er, 1'b0, "entry write error");
    rdchk(ea(1, 3), exp[1][3], 32'h1FF);
    apb(1'b1, evq_pkg::ERROR_MASK_OFS, 32'h0);
    repeat (3) @(posedge mclk);
    cmp(err_irq, 1'b0, "masked irq");
    apb(1'b1, evq_pkg::ERROR_MASK_OFS, 32'hF);
    repeat (3) @(posedge mclk);
    cmp(err_irq, 1'b1, "unmasked irq");
    $display("test fill done");
    stall <= 4'h0;
    send(evt_quick, evt_channel, evt_trig, 100);
    cmp(ok, 1'b1, "pending accepted");
    drain();
    rdchk(sa(1), 32'h00100001, 32'h001F1F0F);
    rdchk(ea(1, 0), exp[1][16], 32'h1FF);
    rdchk(ea(1, 1), exp[1][1], 32'h1FF);
    apb(1'b1, evq_pkg::CONTROLLER_ERROR_REG_OFS, 32'h2);
    repeat (3) @(posedge mclk);
    cmp(err_irq, 1'b0, "cleared irq");
    rdchk(sa(1), 32'h0, 32'h01000000);
    $display("test drain done");
    send(1'b0, 6'h16, evq_pkg::TRIG_EVENT, 10);
    cmp(request_valid[2], 1'b1, "bypass slot");
    rdchk(sa(2), 32'h0, 32'h001F1F0F);
    $display("test bypass done");
    stall <= 4'hF;
    repeat (2) @(posedge mclk);
    send(1'b0, 6'h02, evq_pkg::TRIG_AUTO, 10);
    send(1'b0, 6'h00, evq_pkg::TRIG_CHAINED, 10);
    u_tc.order.delete();
    stall <= 4'h0;
    drain();
    cmp(u_tc.order[0], 32'h0, "first unloaded");
    cmp(u_tc.order[1], 32'h2, "second unloaded");
    $display("test priority done");
    apb(1'b1, 12'h800, 32'h0);
    cmp(er, 1'b1, "unmapped error");
    apb(1'b0, 12'h026, 32'h0);
    cmp(er, 1'b1, "misaligned error");
    for (int i = 0; i < 40; i++) begin
      stall <= 4'($random(seed));
      qk = 1'($random(seed));
      ch = 6'($random(seed));
      send(qk, qk ? {4'h0, ch[1:0]} : ch, evq_pkg::trig_type'(2'($random(seed))), 50);
      stall <= ok ? stall : 4'h0;
      if (!ok) send(evt_quick, evt_channel, evt_trig, 100);
    end
    stall <= 4'h0;
    drain();
    for (int q = 0; q < 4; q++) begin
      cmp(u_tc.log[q].size(), exp[q].size(), "taken count");
      foreach (exp[q][i]) cmp(u_tc.log[q][i], exp[q][i], "taken order");
    end
    $display("test random done");
    end_of_test();
  end
endmodule
